// ===== shared/fbas_cfg.svh
// Constants for the flash block access and security logic
`ifndef FBAS_CFG_SVH
`define FBAS_CFG_SVH

// ==========================================================
// Command space offsets
`define FBAS_OFS_CTL_LO 8'h00
`define FBAS_OFS_CTL_HI 8'h01
`define FBAS_OFS_CLASS 8'h3E
`define FBAS_OFS_BLOCK 8'h3F
`define FBAS_OFS_WIN 8'h40
`define FBAS_OFS_WIN_END 8'h5F
`define FBAS_OFS_CKSUM 8'h60
`define FBAS_OFS_BAC 8'h61

// ==========================================================
// Values and layouts
`define FBAS_BAC_GENERAL 8'h00
`define FBAS_BLK_BYTES 32
`define FBAS_WCNT_MAX 6'h20
`define FBAS_CKSUM_BASE 8'hFF
`define FBAS_USER_CLASS 8'h3A
`define FBAS_USER_BLOCKS 3
`define FBAS_USER_FIRST 8'h01
`define FBAS_USER_LAST 8'h03
`define FBAS_KEY_CLASS 8'h70
`define FBAS_KEY_BYTES 8
`define FBAS_KEY_UNLOCK 0
`define FBAS_KEY_PRIV 4
`define FBAS_LOCK_CMD 16'h0020
`define FBAS_STAT_LOCKED_BIT 5
`define FBAS_STAT_PRIV_BIT 6
`define FBAS_I2C_ADDR 7'h55
`define FBAS_BIT_LAST 4'h8
// Default keys as read back, byte 0 first; values are arbitrary
`define FBAS_DEF_KEYS 64'h1234_5678_ABCD_EF01

`endif

// ===== shared/fbas_pkg.sv
// Types shared by the flash block access and security logic
`include "fbas_cfg.svh"
package fbas_pkg;

  typedef enum logic [1:0] {
    FBAS_MODE_LOCKED = 2'b00,
    FBAS_MODE_OPENED = 2'b01,
    FBAS_MODE_PRIV = 2'b11
  } fbas_mode_e;

  // Gray codes along address, ack, command, data
  typedef enum logic [2:0] {
    FBAS_ST_IDLE = 3'b000,
    FBAS_ST_ADDR = 3'b001,
    FBAS_ST_AACK = 3'b011,
    FBAS_ST_CMD = 3'b010,
    FBAS_ST_DACK = 3'b110,
    FBAS_ST_WR = 3'b111,
    FBAS_ST_RD = 3'b101,
    FBAS_ST_RACK = 3'b100
  } fbas_state_e;

  typedef enum logic [1:0] {
    FBAS_TGT_NONE = 2'b00,
    FBAS_TGT_GEN = 2'b01,
    FBAS_TGT_USER = 2'b10,
    FBAS_TGT_KEY = 2'b11
  } fbas_tgt_e;

  typedef struct packed {
    fbas_tgt_e kind;
    logic [7:0] idx;
  } fbas_target_s;

  typedef struct packed {
    logic valid;
    logic over;
    logic [7:0] addr;
    logic [7:0] data;
  } fbas_wr_s;

endpackage

// ===== verilog/fbas_top.sv
// Flash block access and security logic behind an I2C command space
`timescale 1ns/1ns
`default_nettype none
`include "fbas_cfg.svh"

module fbas_top #(
  parameter int GEN_BLOCKS = 8,
  parameter logic [6:0] DEV_ADDR = `FBAS_I2C_ADDR
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // I2C pins
  input wire logic i_scl,
  input wire logic i_sda_in,
  output logic o_sda_out,
  output logic o_sda_oe,
  // Status
  output logic o_locked,
  output logic o_privileged_state_bit
);

  localparam int BB = `FBAS_BLK_BYTES;
  localparam int GW = (GEN_BLOCKS > 1) ? $clog2(GEN_BLOCKS) : 1;

  // ==========================================================
  // Pin synchronisers and bus events
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_q;
  logic sda_q;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], i_scl};
      sda_sync <= {sda_sync[0], i_sda_in};
      scl_q <= scl_sync[1];
      sda_q <= sda_sync[1];
    end
  end

  assign scl = scl_sync[1];
  assign sda = sda_sync[1];
  assign scl_rise = scl & ~scl_q;
  assign scl_fall = ~scl & scl_q;
  assign start_ev = scl & scl_q & sda_q & ~sda;
  assign stop_ev = scl & scl_q & ~sda_q & sda;

  // ==========================================================
  // Storage; contents survive i_reset, as non-volatile cells should
  logic [7:0] user_nv [`FBAS_USER_BLOCKS*BB] = '{default: 8'h00};
  logic [7:0] gen_nv [GEN_BLOCKS*BB] = '{default: 8'h00};
  logic [7:0] key_nv [`FBAS_KEY_BYTES] = '{8'h12, 8'h34, 8'h56, 8'h78,
                                           8'hAB, 8'hCD, 8'hEF, 8'h01};

  // ==========================================================
  // Command space state
  fbas_pkg::fbas_state_e state;
  fbas_pkg::fbas_mode_e mode;
  fbas_pkg::fbas_wr_s wr_ev;
  fbas_pkg::fbas_target_s target;
  fbas_pkg::fbas_target_s load_tgt;
  logic [7:0] window [BB];
  logic [7:0] shreg;
  logic [7:0] tx;
  logic [7:0] ptr;
  logic [7:0] rd_addr;
  logic [7:0] rdata;
  logic [3:0] bitcnt;
  logic [5:0] win_cnt;
  logic rw;
  logic nack;
  logic [7:0] ctl_lo;
  logic key_armed;
  logic [7:0] class_sel;
  logic [7:0] block_sel;
  logic [7:0] bac;
  logic [7:0] cksum;
  logic win_bad;
  logic user_mode;
  logic load_req;
  logic commit_ok;
  logic [15:0] ctl_word;
  logic [15:0] key_first;
  logic [15:0] key_second;

  function automatic logic in_window(input logic [7:0] a);
    in_window = (a >= `FBAS_OFS_WIN) && (a <= `FBAS_OFS_WIN_END);
  endfunction

  // Window bytes and the checksum byte both count toward one block write
  function automatic logic in_span(input logic [7:0] a);
    in_span = in_window(a) || (a == `FBAS_OFS_CKSUM);
  endfunction

  // Entered words are the stored bytes swapped
  function automatic logic [15:0] key_word(input int base);
    key_word = {key_nv[base + 1], key_nv[base]};
  endfunction

  function automatic fbas_pkg::fbas_target_s tgt_of(input logic um, input logic [7:0] cls,
                                                    input logic [7:0] blk);
    tgt_of.kind = fbas_pkg::FBAS_TGT_NONE;
    tgt_of.idx = 8'h00;
    if (um) begin
      if (blk >= `FBAS_USER_FIRST && blk <= `FBAS_USER_LAST) begin
        tgt_of.kind = fbas_pkg::FBAS_TGT_USER;
        tgt_of.idx = blk - `FBAS_USER_FIRST;
      end
    end else if (cls == `FBAS_USER_CLASS) begin
      if (blk < 8'(`FBAS_USER_BLOCKS)) begin
        tgt_of.kind = fbas_pkg::FBAS_TGT_USER;
        tgt_of.idx = blk;
      end
    end else if (cls == `FBAS_KEY_CLASS) begin
      if (blk == 8'h00) begin
        tgt_of.kind = fbas_pkg::FBAS_TGT_KEY;
      end
    end else begin
      // Class plus block select, cut to GW bits, picks the 32-byte block
      tgt_of.kind = fbas_pkg::FBAS_TGT_GEN;
      tgt_of.idx = 8'(GW'(cls + blk));
    end
  endfunction

  function automatic logic [7:0] src_byte(input fbas_pkg::fbas_target_s t, input int i);
    case (t.kind)
      fbas_pkg::FBAS_TGT_GEN: src_byte = gen_nv[int'(t.idx) * BB + i];
      fbas_pkg::FBAS_TGT_USER: src_byte = user_nv[int'(t.idx) * BB + i];
      fbas_pkg::FBAS_TGT_KEY: src_byte = (i < `FBAS_KEY_BYTES) ? key_nv[i] : 8'h00;
      default: src_byte = 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] win_sum();
    win_sum = 8'h00;
    for (int i = 0; i < BB; i++) begin
      win_sum = win_sum + window[i];
    end
  endfunction

  // ==========================================================
  // I2C slave
  assign rd_addr = (state == fbas_pkg::FBAS_ST_RACK) ? ptr + 8'h01 : ptr;

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state <= fbas_pkg::FBAS_ST_IDLE;
      shreg <= 8'h00;
      tx <= 8'h00;
      ptr <= 8'h00;
      bitcnt <= 4'h0;
      win_cnt <= 6'h00;
      rw <= 1'b0;
      nack <= 1'b0;
      o_sda_oe <= 1'b0;
      wr_ev <= '0;
    end else begin
      wr_ev.valid <= 1'b0;
      if (start_ev) begin
        state <= fbas_pkg::FBAS_ST_ADDR;
        bitcnt <= 4'h0;
        win_cnt <= 6'h00;
        o_sda_oe <= 1'b0;
      end else if (stop_ev) begin
        state <= fbas_pkg::FBAS_ST_IDLE;
        o_sda_oe <= 1'b0;
      end else if (scl_rise) begin
        case (state)
          fbas_pkg::FBAS_ST_ADDR, fbas_pkg::FBAS_ST_CMD, fbas_pkg::FBAS_ST_WR: begin
            shreg <= {shreg[6:0], sda};
            bitcnt <= bitcnt + 4'h1;
          end
          fbas_pkg::FBAS_ST_RACK: nack <= sda;
          default: ;
        endcase
      end else if (scl_fall) begin
        case (state)
          fbas_pkg::FBAS_ST_ADDR: begin
            if (bitcnt == `FBAS_BIT_LAST) begin
              if (shreg[7:1] == DEV_ADDR) begin
                o_sda_oe <= 1'b1;
                rw <= shreg[0];
                state <= fbas_pkg::FBAS_ST_AACK;
              end else begin
                state <= fbas_pkg::FBAS_ST_IDLE;
              end
            end
          end
          fbas_pkg::FBAS_ST_AACK: begin
            bitcnt <= rw ? 4'h1 : 4'h0;
            o_sda_oe <= rw ? ~rdata[7] : 1'b0;
            tx <= {rdata[6:0], 1'b0};
            state <= rw ? fbas_pkg::FBAS_ST_RD : fbas_pkg::FBAS_ST_CMD;
          end
          fbas_pkg::FBAS_ST_CMD: begin
            if (bitcnt == `FBAS_BIT_LAST) begin
              ptr <= shreg;
              o_sda_oe <= 1'b1;
              state <= fbas_pkg::FBAS_ST_DACK;
            end
          end
          fbas_pkg::FBAS_ST_WR: begin
            if (bitcnt == `FBAS_BIT_LAST) begin
              wr_ev.valid <= 1'b1;
              wr_ev.over <= in_span(ptr) && (win_cnt >= `FBAS_WCNT_MAX);
              wr_ev.addr <= ptr;
              wr_ev.data <= shreg;
              if (in_span(ptr) && win_cnt <= `FBAS_WCNT_MAX) begin
                win_cnt <= win_cnt + 6'h01;
              end
              ptr <= ptr + 8'h01;
              o_sda_oe <= 1'b1;
              state <= fbas_pkg::FBAS_ST_DACK;
            end
          end
          fbas_pkg::FBAS_ST_DACK: begin
            o_sda_oe <= 1'b0;
            bitcnt <= 4'h0;
            state <= fbas_pkg::FBAS_ST_WR;
          end
          fbas_pkg::FBAS_ST_RD: begin
            if (bitcnt == `FBAS_BIT_LAST) begin
              o_sda_oe <= 1'b0;
              state <= fbas_pkg::FBAS_ST_RACK;
            end else begin
              o_sda_oe <= ~tx[7];
              tx <= {tx[6:0], 1'b0};
              bitcnt <= bitcnt + 4'h1;
            end
          end
          fbas_pkg::FBAS_ST_RACK: begin
            if (nack) begin
              state <= fbas_pkg::FBAS_ST_IDLE;
            end else begin
              ptr <= ptr + 8'h01;
              o_sda_oe <= ~rdata[7];
              tx <= {rdata[6:0], 1'b0};
              bitcnt <= 4'h1;
              state <= fbas_pkg::FBAS_ST_RD;
            end
          end
          default: state <= fbas_pkg::FBAS_ST_IDLE;
        endcase
      end
    end
  end

  // SDA is open drain: only ever pulled low
  always_ff @(posedge i_clk_sys) begin
    o_sda_out <= 1'b0;
  end

  // ==========================================================
  // Read mux: every window byte can be read on its own
  always_comb begin
    rdata = 8'h00;
    if (in_window(rd_addr)) begin
      rdata = window[5'(rd_addr - `FBAS_OFS_WIN)];
    end else begin
      case (rd_addr)
        `FBAS_OFS_CTL_HI: begin
          rdata[`FBAS_STAT_LOCKED_BIT] = o_locked;
          rdata[`FBAS_STAT_PRIV_BIT] = o_privileged_state_bit;
        end
        `FBAS_OFS_CLASS: rdata = class_sel;
        `FBAS_OFS_BLOCK: rdata = block_sel;
        `FBAS_OFS_CKSUM: rdata = cksum;
        `FBAS_OFS_BAC: rdata = bac;
        default: rdata = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Security modes and key entry
  assign ctl_word = {wr_ev.data, ctl_lo};
  // A process, not an assign: the key store is read inside the function
  always_comb begin
    key_first = key_word((mode == fbas_pkg::FBAS_MODE_LOCKED) ? `FBAS_KEY_UNLOCK
                         : `FBAS_KEY_PRIV);
    key_second = key_word(((mode == fbas_pkg::FBAS_MODE_LOCKED) ? `FBAS_KEY_UNLOCK
                           : `FBAS_KEY_PRIV) + 2);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      mode <= fbas_pkg::FBAS_MODE_LOCKED;
      ctl_lo <= 8'h00;
      key_armed <= 1'b0;
    end else if (wr_ev.valid && wr_ev.addr == `FBAS_OFS_CTL_LO) begin
      ctl_lo <= wr_ev.data;
    end else if (wr_ev.valid && wr_ev.addr == `FBAS_OFS_CTL_HI) begin
      if (ctl_word == `FBAS_LOCK_CMD) begin
        mode <= fbas_pkg::FBAS_MODE_LOCKED;
        key_armed <= 1'b0;
      end else if (key_armed && ctl_word == key_second) begin
        mode <= (mode == fbas_pkg::FBAS_MODE_LOCKED) ? fbas_pkg::FBAS_MODE_OPENED
                : fbas_pkg::FBAS_MODE_PRIV;
        key_armed <= 1'b0;
      end else begin
        // Any other word voids a half-entered pair
        key_armed <= (mode != fbas_pkg::FBAS_MODE_PRIV) && (ctl_word == key_first);
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_locked <= 1'b1;
      o_privileged_state_bit <= 1'b1;
    end else begin
      o_locked <= (mode == fbas_pkg::FBAS_MODE_LOCKED);
      o_privileged_state_bit <= (mode != fbas_pkg::FBAS_MODE_PRIV);
    end
  end

  // ==========================================================
  // Block selection, window and commit
  // Locked, or access control not general, means user-block select
  assign user_mode = (mode == fbas_pkg::FBAS_MODE_LOCKED) || (bac != `FBAS_BAC_GENERAL);

  always_comb begin
    load_req = 1'b0;
    load_tgt = tgt_of(user_mode, class_sel, wr_ev.data);
    if (wr_ev.valid && wr_ev.addr == `FBAS_OFS_BLOCK) begin
      load_req = 1'b1;
    end else if (wr_ev.valid && wr_ev.addr == `FBAS_OFS_CLASS && !user_mode) begin
      load_req = 1'b1;
      load_tgt = tgt_of(1'b0, wr_ev.data, block_sel);
    end
  end

  // No range check on contents; only the checksum, the byte count, the mode and the target block gate a commit
  always_comb begin
    commit_ok = 1'b0;
    if (wr_ev.valid && wr_ev.addr == `FBAS_OFS_CKSUM && !win_bad && !wr_ev.over &&
        wr_ev.data == `FBAS_CKSUM_BASE - win_sum()) begin
      case (target.kind)
        fbas_pkg::FBAS_TGT_GEN: commit_ok = (mode != fbas_pkg::FBAS_MODE_LOCKED);
        fbas_pkg::FBAS_TGT_USER:
          commit_ok = !(mode == fbas_pkg::FBAS_MODE_LOCKED && target.idx == 8'h00);
        fbas_pkg::FBAS_TGT_KEY: commit_ok = (mode == fbas_pkg::FBAS_MODE_PRIV);
        default: commit_ok = 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      class_sel <= 8'h00;
      block_sel <= 8'h00;
      bac <= `FBAS_BAC_GENERAL;
    end else if (wr_ev.valid && mode != fbas_pkg::FBAS_MODE_LOCKED &&
                 wr_ev.addr == `FBAS_OFS_CLASS) begin
      class_sel <= wr_ev.data;
    end else if (wr_ev.valid && mode != fbas_pkg::FBAS_MODE_LOCKED &&
                 wr_ev.addr == `FBAS_OFS_BAC) begin
      bac <= wr_ev.data;
    end else if (wr_ev.valid && wr_ev.addr == `FBAS_OFS_BLOCK) begin
      block_sel <= wr_ev.data;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      target <= '0;
      cksum <= 8'h00;
      win_bad <= 1'b0;
      for (int i = 0; i < BB; i++) begin
        window[i] <= 8'h00;
      end
    end else if (load_req) begin
      target <= load_tgt;
      win_bad <= 1'b0;
      for (int i = 0; i < BB; i++) begin
        window[i] <= src_byte(load_tgt, i);
      end
    end else if (wr_ev.valid && wr_ev.over) begin
      // Bytes past the 32nd are dropped and spoil the block until reloaded
      win_bad <= 1'b1;
    end else if (wr_ev.valid && in_window(wr_ev.addr)) begin
      window[5'(wr_ev.addr - `FBAS_OFS_WIN)] <= wr_ev.data;
    end else if (wr_ev.valid && wr_ev.addr == `FBAS_OFS_CKSUM) begin
      cksum <= wr_ev.data; // A mismatch keeps window for retry
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (commit_ok) begin
      for (int i = 0; i < BB; i++) begin
        if (target.kind == fbas_pkg::FBAS_TGT_GEN) begin
          gen_nv[int'(target.idx) * BB + i] <= window[i];
        end
        if (target.kind == fbas_pkg::FBAS_TGT_USER) begin
          user_nv[int'(target.idx) * BB + i] <= window[i];
        end
        if (target.kind == fbas_pkg::FBAS_TGT_KEY && i < `FBAS_KEY_BYTES) begin
          key_nv[i] <= window[i];
        end
      end
    end
  end

endmodule

`default_nettype wire

// ===== dv/fbas_top_asserts.sv
// Port checker for the flash block access and security logic
`timescale 1ns/1ns
`default_nettype none

module fbas_top_asserts (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // I2C pins
  input wire logic i_scl,
  input wire logic i_sda_in,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  // Status
  input wire logic o_locked,
  input wire logic o_privileged_state_bit
);
  logic scl_q;
  logic [7:0] since_fall;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);

  // ==========
  // Clocks since the last SCL fall, saturating so idle time cannot wrap
  always_ff @(posedge i_clk_sys) begin
    scl_q <= i_scl;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      since_fall <= 8'hFF;
    end else if (scl_q && !i_scl) begin
      since_fall <= 8'h00;
    end else if (since_fall != 8'hFF) begin
      since_fall <= since_fall + 8'h01;
    end
  end

  sequence s_ack_hold;
    o_sda_oe [*4];
  endsequence

  sequence s_low_phase;
    !i_scl && since_fall <= 8'h03;
  endsequence

  sequence s_byte_done;
    since_fall <= 8'h08;
  endsequence

  // ==========
  // Assertions
  AST_RESET_STATE:
  assert property ($fell(i_reset) |-> o_locked && o_privileged_state_bit && !o_sda_oe)
    else $error("status or SDA drive wrong after reset");
  AST_OPEN_DRAIN:
  assert property (o_sda_out == 1'b0)
    else $error("SDA driven high");
  AST_SDA_ON_LOW:
  assert property ($changed(o_sda_oe) |-> s_low_phase)
    else $error("SDA changed outside early SCL low phase");
  AST_ACK_HOLD:
  assert property ($rose(o_sda_oe) |-> s_ack_hold)
    else $error("SDA pull released too early");
  AST_LOCK_AT_BYTE:
  assert property ($changed(o_locked) |-> s_byte_done)
    else $error("locked status changed away from a byte end");
  AST_PRIV_AT_BYTE:
  assert property ($changed(o_privileged_state_bit) |-> s_byte_done)
    else $error("privileged status changed away from a byte end");
  AST_PRIV_FROM_OPEN:
  assert property ($fell(o_privileged_state_bit) |-> !o_locked && !$past(o_locked))
    else $error("privileged entered while locked");
  AST_LOCK_DROPS_PRIV:
  assert property ($rose(o_locked) |-> ##[0:2] o_privileged_state_bit)
    else $error("privileged status kept after locking");
endmodule

bind fbas_top fbas_top_asserts fbas_top_asserts_i (
  .i_clk_sys(i_clk_sys),
  .i_reset(i_reset),
  .i_scl(i_scl),
  .i_sda_in(i_sda_in),
  .o_sda_out(o_sda_out),
  .o_sda_oe(o_sda_oe),
  .o_locked(o_locked),
  .o_privileged_state_bit(o_privileged_state_bit)
);

`default_nettype wire

// ===== dv/fbas_host_model.sv
// I2C host model that reaches the command space of the block
`timescale 1ns/1ns
`default_nettype none

module fbas_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h55
) (
  // Clock
  input wire logic i_clk_sys,
  // Bus
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe
);
  int nack_cnt = 0;

  // SCL idles high and only toggles inside frames
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end

  // ==========
  // Bit level: 4 clocks low, 4 high, 320 ns per bit
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask

  // Also a repeated start: SDA is released before SCL rises
  task automatic start();
    o_sda_oe <= 1'b0;
    tick(2);
    o_scl <= 1'b1;
    tick(4);
    o_sda_oe <= 1'b1;
    tick(4);
    o_scl <= 1'b0;
    tick(2);
  endtask

  task automatic stop();
    o_sda_oe <= 1'b1;
    tick(2);
    o_scl <= 1'b1;
    tick(4);
    o_sda_oe <= 1'b0;
    tick(4);
  endtask

  task automatic bit_io(input logic b, output logic r);
    o_sda_oe <= !b;
    tick(2);
    o_scl <= 1'b1;
    tick(2);
    r = i_sda;
    tick(2);
    o_scl <= 1'b0;
    tick(2);
  endtask

  task automatic put(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    if (r !== 1'b0) begin
      nack_cnt++;
    end
  endtask

  // ==========
  // Transfers: pointer byte first, then auto-incremented data
  task automatic wr(input logic [7:0] a, input logic [7:0] d[$]);
    start();
    put({DEV_ADDR, 1'b0});
    put(a);
    foreach (d[i]) begin
      put(d[i]);
    end
    stop();
  endtask

  task automatic rd(input logic [7:0] a, input int n, output logic [7:0] q[$]);
    logic [7:0] b;
    logic r;
    q = {};
    start();
    put({DEV_ADDR, 1'b0});
    put(a);
    start();
    put({DEV_ADDR, 1'b1});
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        bit_io(1'b1, r);
        b[i] = r;
      end
      bit_io(k == n - 1, r);
      q.push_back(b);
    end
    stop();
  endtask
endmodule

`default_nettype wire

// ===== dv/fbas_tb.sv
// Self-checking bench for the flash block access and security logic
`timescale 1ns/1ns
`default_nettype none

module tb;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic scl;
  logic host_oe;
  logic sda;
  logic sda_out;
  logic sda_oe;
  logic locked;
  logic priv;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [7:0] img[$];
  logic [7:0] q[$];

  // ==========
  // Clock, wire and instances
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  // Pull-up: low while either side pulls
  assign sda = (host_oe || sda_oe) ? 1'b0 : 1'b1;

  fbas_top fbas_top_i (
    .i_clk_sys(clk_sys),
    .i_reset(reset),
    .i_scl(scl),
    .i_sda_in(sda),
    .o_sda_out(sda_out),
    .o_sda_oe(sda_oe),
    .o_locked(locked),
    .o_privileged_state_bit(priv)
  );

  fbas_host_model fbas_host_model_i (
    .i_clk_sys(clk_sys),
    .i_sda(sda),
    .o_scl(scl),
    .o_sda_oe(host_oe)
  );

  // ==========
  // Shared tasks
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d[$]);
    fbas_host_model_i.wr(a, d);
  endtask

  task automatic rd(input logic [7:0] a, input int n);
    fbas_host_model_i.rd(a, n, q);
  endtask

  function automatic logic [7:0] cks();
    logic [7:0] s;
    s = 8'h00;
    foreach (img[i]) begin
      s += img[i];
    end
    return 8'hFF - s;
  endfunction

  task automatic fill(input logic [7:0] s);
    img = {};
    for (int i = 0; i < 32; i++) begin
      img.push_back(s == 8'h00 ? 8'h00 : s + 8'(i));
    end
  endtask

  task automatic sel(input logic [7:0] c, input logic [7:0] b);
    wr(8'h3E, '{c, b});
  endtask

  task automatic put_blk(input logic good);
    wr(8'h40, img);
    wr(8'h60, '{good ? cks() : ~cks()});
  endtask

  task automatic chk_blk(input string name);
    rd(8'h40, 32);
    foreach (img[i]) begin
      check(name, {8'h00, q[i]}, {8'h00, img[i]});
    end
  endtask

  task automatic ctl(input logic [15:0] w);
    wr(8'h00, '{w[7:0], w[15:8]});
  endtask

  task automatic st(input logic l, input logic p);
    check("locked", {15'h0000, locked}, {15'h0000, l});
    check("privileged", {15'h0000, priv}, {15'h0000, p});
  endtask

  // ==========
  // Scenarios
  task automatic t_locked();
    st(1'b1, 1'b1);
    rd(8'h01, 1);
    check("status", {8'h00, q[0] & 8'h60}, 16'h0060);
    sel(8'h00, 8'h02);
    fill(8'h20);
    put_blk(1'b1);
    sel(8'h00, 8'h01);
    fill(8'h50);
    put_blk(1'b1);
    sel(8'h00, 8'h03);
    fill(8'h30);
    put_blk(1'b0);
    sel(8'h00, 8'h02);
    fill(8'h20);
    chk_blk("user b");
    // The access-control and class writes must be dropped while locked
    wr(8'h61, '{8'h01});
    sel(8'h3A, 8'h01);
    rd(8'h3E, 1);
    check("class", {8'h00, q[0]}, 16'h0000);
    rd(8'h61, 1);
    check("access", {8'h00, q[0]}, 16'h0000);
    fill(8'h00);
    chk_blk("user a");
    sel(8'h00, 8'h03);
    chk_blk("user c");
  endtask

  task automatic t_keys();
    ctl(16'h3412);
    ctl(16'h0000);
    ctl(16'h7856);
    st(1'b1, 1'b1);
    ctl(16'h1234);
    ctl(16'h5678);
    st(1'b1, 1'b1);
    ctl(16'h3412);
    ctl(16'h7856);
    st(1'b0, 1'b1);
  endtask

  task automatic t_open();
    wr(8'h61, '{8'h00});
    sel(8'h3A, 8'h01);
    fill(8'h20);
    chk_blk("subclass b");
    sel(8'h50, 8'h01);
    fill(8'h60);
    put_blk(1'b1);
    wr(8'h50, '{8'hEE});
    wr(8'h60, '{cks()});
    sel(8'h50, 8'h01);
    rd(8'h50, 1);
    check("item kept", {8'h00, q[0]}, 16'h0070);
    img[16] = 8'hEE;
    wr(8'h50, '{8'hEE});
    wr(8'h60, '{cks()});
    sel(8'h50, 8'h01);
    rd(8'h50, 1);
    check("item", {8'h00, q[0]}, 16'h00EE);
    sel(8'h50, 8'h00);
    rd(8'h50, 1);
    check("block 0", {8'h00, q[0]}, 16'h0000);
    wr(8'h61, '{8'h01});
    sel(8'h00, 8'h01);
    fill(8'h00);
    chk_blk("a by select");
    fill(8'h50);
    put_blk(1'b1);
    sel(8'h00, 8'h01);
    chk_blk("a opened");
    // 33 bytes: the 33rd lands on the checksum and must be dropped
    fill(8'h10);
    img.push_back(cks());
    wr(8'h40, img);
    wr(8'h60, '{img[32]});
    sel(8'h00, 8'h01);
    fill(8'h50);
    chk_blk("a overlong");
  endtask

  task automatic t_priv();
    wr(8'h61, '{8'h00});
    sel(8'h70, 8'h00);
    fill(8'h90);
    put_blk(1'b1);
    sel(8'h70, 8'h00);
    rd(8'h40, 2);
    check("key kept", {q[0], q[1]}, 16'h1234);
    ctl(16'hCDAB);
    ctl(16'h01EF);
    st(1'b0, 1'b0);
    put_blk(1'b1);
    sel(8'h70, 8'h00);
    rd(8'h40, 2);
    check("key new", {q[0], q[1]}, 16'h9091);
    ctl(16'h0020);
    st(1'b1, 1'b1);
    // Keys must survive a reset: they live in the store
    reset <= 1'b1;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (3) @(posedge clk_sys);
    ctl(16'h9190);
    ctl(16'h9392);
    st(1'b0, 1'b1);
  endtask

  // ==========
  // Main sequence and hang guard
  initial begin
    repeat (100000) @(posedge clk_sys);
    error_cnt++;
    results();
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (3) @(posedge clk_sys);
    t_locked();
    t_keys();
    t_open();
    t_priv();
    check("acks", 16'(fbas_host_model_i.nack_cnt), 16'h0000);
    results();
  end
endmodule

`default_nettype wire
